//--- sram_host.sv
// host controller driving an asynchronous 32k x 8 static ram
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - write strobe stays high for the whole read cycle
// - address becomes valid at the same edge that chip select falls on a read
// - write starts with all controls active; first rising strobe ends it
// - write data stable at least 12 ns before the terminating edge
// - write data may change at the terminating edge
// - address stable at least 15 ns before the terminating edge
// - address may change at the terminating edge
// - chip select already high before entering data retention
module sram_host
    import sram_host_pkg::*;
#(
    parameter int RC_CNT  = RC_CYC,
    parameter int WC_CNT  = WC_CYC,
    parameter int PWE_CNT = PWE_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // user request side
    input  wire logic              req_valid,
    input  wire req_s              req,
    output logic                   req_ready,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   rd_valid,
    // data retention control
    input  wire logic              retain_req,
    output logic                   retain_ok,
    // memory pins
    output pins_s                  pins,
    input  wire logic [DATA_W-1:0] data_in
);

    ////////////////////////////////////////////////////////////////////////
    // sequencer: state and the cycle counter that times every phase except idle and retention
    state_e             state_ff, nxt_state;
    logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
    // every memory pin leaves a flip-flop, so no decode glitch
    // can open a stray write overlap at the device
    pins_s              pins_ff, nxt_pins;
    // read capture
    logic [DATA_W-1:0]  rd_data_ff, nxt_rd_data;
    logic               rd_valid_ff, nxt_rd_valid;
    // events decoded from the present state and count
    logic               idle;
    logic               rd_last;
    logic               wr_last;
    logic               rec_last;
    logic               wake_last;

    assign pins      = pins_ff;
    assign rd_data   = rd_data_ff;
    assign rd_valid  = rd_valid_ff;
    assign idle      = (state_ff == ST_IDLE);
    // retention wins over a waiting request, so ready drops with retain_req
    assign req_ready = idle && !retain_req;
    assign retain_ok = (state_ff == ST_RETAIN);
    // sample only after a full read cycle time
    assign rd_last   = (state_ff == ST_READ) && (cnt_ff == CNT_W'(RC_CNT - 1));
    // data and address held from start; data well past setup, address just meets it
    assign wr_last   = (state_ff == ST_WRITE) && (cnt_ff == CNT_W'(PWE_CNT - 1));
    assign rec_last  = (state_ff == ST_RECOVER) && (cnt_ff >= CNT_W'(WC_CNT - 1));
    // one read cycle time before the first access
    assign wake_last = (state_ff == ST_WAKE) && (cnt_ff == CNT_W'(RC_CNT - 1));

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (retain_req) begin
                    nxt_state = ST_RETAIN;
                end else if (req_valid) begin
                    nxt_cnt = '0;
                    if (req.write) begin
                        nxt_state = ST_WRITE;
                    end else begin
                        nxt_state = ST_READ;
                    end
                end
            end
            ST_READ: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (rd_last) begin
                    nxt_cnt   = '0;
                    nxt_state = ST_RECOVER;
                end
            end
            ST_WRITE: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (wr_last) begin
                    // recovery resumes the count where the strobe ended, so a
                    // write cycle is padded only to the write cycle time
                    nxt_cnt   = CNT_W'(PWE_CNT);
                    nxt_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // pads a write out to the write cycle time and follows a read with a full
                // write cycle time, which also covers the output float time after a read
                nxt_cnt = cnt_ff + 1'b1;
                if (rec_last) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_RETAIN: begin
                if (!retain_req) begin
                    nxt_cnt   = '0;
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (wake_last) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_pins = pins_ff;
        case (state_ff)
            ST_IDLE: begin
                if (retain_req) begin
                    nxt_pins.chip_sel_n = 1'b1;
                    nxt_pins.out_en_n   = 1'b1;
                    nxt_pins.write_n    = 1'b1;
                    nxt_pins.data_oe    = 1'b0;
                end else if (req_valid) begin
                    // address with the select edge, never after
                    nxt_pins.address_bus = req.addr;
                    nxt_pins.chip_sel_n  = 1'b0;
                    if (req.write) begin
                        // all controls active together to start the write
                        nxt_pins.write_n  = 1'b0;
                        nxt_pins.out_en_n = 1'b1;
                        nxt_pins.data_out = req.wdata;
                        nxt_pins.data_oe  = 1'b1;
                    end else begin
                        nxt_pins.write_n  = 1'b1;
                        nxt_pins.out_en_n = 1'b0;
                        nxt_pins.data_oe  = 1'b0;
                    end
                end
            end
            ST_READ: begin
                if (rd_last) begin
                    nxt_pins.chip_sel_n = 1'b1;
                    nxt_pins.out_en_n   = 1'b1;
                end
            end
            ST_WRITE: begin
                if (wr_last) begin
                    // strobe and select rise together and end the write
                    nxt_pins.write_n    = 1'b1;
                    nxt_pins.chip_sel_n = 1'b1;
                    // zero hold: bus released at the end edge
                    nxt_pins.data_oe    = 1'b0;
                end
            end
            default: begin
                nxt_pins = pins_ff;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            // strobes idle high and the host floats the bus out of reset
            pins_ff.chip_sel_n  <= 1'b1;
            pins_ff.out_en_n    <= 1'b1;
            pins_ff.write_n     <= 1'b1;
            pins_ff.address_bus <= '0;
            pins_ff.data_out    <= '0;
            pins_ff.data_oe     <= 1'b0;
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_rd_data  = rd_data_ff;
        nxt_rd_valid = 1'b0;
        // the byte is taken at the edge that ends the selection
        if (rd_last) begin
            nxt_rd_data  = data_in;
            nxt_rd_valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

endmodule
`default_nettype wire

//--- sram_host_pkg.sv
// package: pin groups, timing figures and cycle counts for the async sram host
package sram_host_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_PS = 5000;

    // speed grade 25 ns, figures in picoseconds
    localparam int T_RC_PS  = 25000;
    localparam int T_WC_PS  = 25000;
    localparam int T_AA_PS  = 25000;
    localparam int T_PWE_PS = 15000;
    localparam int T_SCS_PS = 15000;
    localparam int T_AW_PS  = 15000;
    localparam int T_SD_PS  = 12000;
    localparam int T_HZ_PS  = 12000;

    // least times round up, never below one cycle
    localparam int RC_CYC  = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WC_CYC  = (T_WC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AA_CYC  = (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PWE_CYC = (T_PWE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCS_CYC = (T_SCS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HZ_CYC  = (T_HZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SD_CYC  = (T_SD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int CNT_W = 8;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_s;

    typedef struct packed {
        logic              chip_sel_n;
        logic              out_en_n;
        logic              write_n;
        logic [ADDR_W-1:0] address_bus;
        logic [DATA_W-1:0] data_out;
        logic              data_oe;
    } pins_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_RECOVER,
        ST_RETAIN,
        ST_WAKE
    } state_e;

endpackage

//--- sram_host_sva.sv
// checker: pin timing of the sram host
`timescale 1ns/1ps
`default_nettype none
module sram_host_sva
    import sram_host_pkg::*;
(
    // watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire req_s req,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic retain_ok,
    input wire pins_s pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence rd_take; req_valid && req_ready && !req.write; endsequence
    sequence wr_low; !pins.write_n ##1 !pins.write_n; endsequence
    chk_rd_strobe_high: assert property (!pins.out_en_n |-> pins.write_n)
        else $error("strobe low in read");
    chk_wr_all_active: assert property (!pins.write_n |-> !pins.chip_sel_n && pins.data_oe)
        else $error("write without select");
    chk_wr_data_hold: assert property (wr_low |-> $stable(pins.data_out))
        else $error("data moved in write");
    chk_sel_addr_hold: assert property (!pins.chip_sel_n [*2] |-> $stable(pins.address_bus))
        else $error("address moved");
    chk_wr_pulse_len: assert property ($fell(pins.write_n) |-> !pins.write_n [*3])
        else $error("write pulse short");
    chk_ret_desel: assert property (retain_ok |-> pins.chip_sel_n)
        else $error("selected in retention");
    chk_wake_wait: assert property ($fell(retain_ok) |-> !req_ready [*5])
        else $error("wake too short");
    chk_rd_answer: assert property (rd_take |-> ##6 rd_valid)
        else $error("read answer late");
endmodule
bind sram_host sram_host_sva sram_host_sva_inst (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
    .retain_ok(retain_ok), .pins(pins));
`default_nettype wire

//--- sram_model.sv
// behavioural 32k x 8 async static ram on the host pins
`timescale 1ns/1ps
`default_nettype none
module sram_model
    import sram_host_pkg::*;
#(
    parameter int ACC_NS = 20
) (
    // host pins and resolved bus
    input  wire pins_s         pins,
    output logic [DATA_W-1:0] bus
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last = 8'h00;
    // drives only while read-selected, after access time
    wire #(ACC_NS) drive = !pins.chip_sel_n && !pins.out_en_n && pins.write_n;
    // released bus shows the inverse of the last value, never a leftover
    assign bus = pins.data_oe ? pins.data_out : drive ? mem[pins.address_bus] : ~last;
    always @* begin
        if (pins.data_oe)
            last = pins.data_out;
        else if (drive)
            last = mem[pins.address_bus];
    end
    // stores only in the select and strobe overlap
    always @* begin
        if (!pins.chip_sel_n && !pins.write_n)
            mem[pins.address_bus] = bus;
    end
endmodule
`default_nettype wire

//--- sram_host_tb_top.sv
// self-checking bench for the sram host
`timescale 1ns/1ps
`default_nettype none
module sram_host_tb_top import sram_host_pkg::*;;
    logic clk = 0;
    logic reset = 1;
    logic req_valid = 0;
    req_s req = '0;
    logic retain_req = 0;
    logic req_ready, rd_valid, retain_ok;
    logic [DATA_W-1:0] rd_data, data_in, q;
    pins_s pins;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    sram_host sram_host_inst (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .retain_req(retain_req), .retain_ok(retain_ok), .pins(pins), .data_in(data_in));
    sram_model sram_model_inst (.pins(pins), .bus(data_in));
    initial forever #2.5 clk = ~clk;
    task automatic step; @(posedge clk); #1; endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // request held until taken; a read waits for its answer
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid = 1;
        req = {w, a, d};
        while (!req_ready && n < 40) begin
            step;
            n++;
        end
        chk({7'h00, req_ready}, 8'h01);
        step;
        req_valid = 0;
        if (w) step;
        for (n = 0; n < 20 && !w && !rd_valid; n++) step;
        if (!w) chk(8'(n), 8'(RC_CYC));
        q = rd_data;
    endtask
    task automatic t_rw;
        logic [14:0] ad [3] = '{15'h0000, 15'h7FFF, 15'h1234};
        logic [7:0] dt [3] = '{8'h5A, 8'hA5, 8'h3C};
        foreach (ad[i]) begin
            acc(1, ad[i], dt[i]);
            chk({4'h0, req_ready, pins.chip_sel_n, pins.write_n, pins.out_en_n}, 8'h01);
        end
        foreach (ad[i]) begin
            acc(0, ad[i], 8'h00);
            chk(q, dt[i]);
        end
    endtask
    task automatic t_b2b;
        acc(1, 15'h1234, 8'hC3);
        acc(0, 15'h1234, 8'h00);
        chk(q, 8'hC3);
        acc(0, 15'h0000, 8'h00);
        chk(q, 8'h5A);
    endtask
    task automatic t_ret;
        int n;
        retain_req = 1;
        // the previous read is still recovering, so wait for retention itself
        for (n = 0; n < 20 && !retain_ok; n++) step;
        step;
        chk({5'h00, retain_ok, pins.chip_sel_n, req_ready}, 8'h06);
        retain_req = 0;
        acc(0, 15'h7FFF, 8'h00);
        chk(q, 8'hA5);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 reset = 0;
        t_rw;
        t_b2b;
        t_ret;
        conclude;
    end
endmodule
`default_nettype wire
